// file: core/card_file_access.sv
// Command decoder and executor for status, binary and record file access.
`timescale 1ns/1ps
`default_nettype none
`include "card_file_regs.svh"

// How it works
// - Status P1 gives none, initialized, or terminating
// - Status P2 picks select data, name, none
// - Status accepts absent, zero or sized Le
// - Binary read streams bytes when read allowed
// - P1 b8 clear gives fifteen-bit offset
// - P1 100 gives short reference, P2 offset
// - Binary read has no Lc, returns Le bytes
// - Binary update writes Lc bytes when allowed
// - Binary update shares the read P1/P2 decode
// - Record read whole record; failure keeps pointer
// - Current mode reads pointed record, pointer kept
// - Absolute mode reads P1 record, pointer kept
// - Next mode increments; unset pointer goes first
// - Next on linear last record fails
// - Next on cyclic last record wraps first
// - Previous decrements; unset pointer goes last
// - Previous on linear first record fails
// - Previous on cyclic first record wraps last
// - Record P2 zero is current, else reference
// - Mode codes next, previous, absolute/current
module card_file_access
  import card_file_pkg::*;
#(
  parameter int NUM_FILES = 4,
  parameter int FILE_BYTES = 256,
  parameter int FILE_W = (NUM_FILES > 1) ? $clog2(NUM_FILES) : 1,
  parameter int ADDR_W = $clog2(NUM_FILES * FILE_BYTES)
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command request
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  output logic cmd_ready,
  // Update data bytes
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  // File system view
  input wire file_desc_t [NUM_FILES-1:0] file_desc,
  input wire logic [FILE_W-1:0] cur_file,
  input wire logic select_pulse,
  // Response and result
  output rsp_byte_t rsp,
  output result_t result,
  output logic app_init,
  output logic app_term
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_READ,
    S_WRITE
  } state_t;

  state_t state_q;
  logic ready_q;
  logic [ADDR_W-1:0] addr_q;
  logic [8:0] cnt_q;
  logic [7:0] mem [NUM_FILES*FILE_BYTES];
  logic [7:0] ptr_q [NUM_FILES];
  rsp_byte_t rsp_q;
  result_t res_q;
  logic init_q;
  logic term_q;

  // Decode results for the command offered this cycle.
  status_t dec_st;
  logic [FILE_W-1:0] tgt;
  logic [ADDR_W-1:0] start;
  logic [8:0] count;
  logic go_read;
  logic go_write;
  logic ptr_wr;
  logic [7:0] ptr_new;
  stat_resp_t sresp;
  logic ind_init;
  logic ind_term;

  logic accept;
  assign accept = ready_q && cmd_valid;

  // A reference of zero never matches, so files without one are unreachable by it.
  function automatic logic [FILE_W:0] find_sfi(
    input logic [4:0] ref_in,
    input file_desc_t [NUM_FILES-1:0] d
  );
    logic [FILE_W:0] hit;
    hit = '0;
    for (int i = NUM_FILES - 1; i >= 0; i--)
    begin
      if (ref_in != `SFI_CURRENT && d[i].short_file_ref == ref_in)
      begin
        hit = {1'b1, FILE_W'(i)};
      end
    end
    return hit;
  endfunction

  function automatic logic [8:0] le_bytes(input logic [7:0] le);
    return (le == `LE_ZERO) ? `LE_FULL : {1'b0, le};
  endfunction

  function automatic logic [ADDR_W-1:0] base_of(input logic [FILE_W-1:0] idx);
    return ADDR_W'(ADDR_W'(idx) * ADDR_W'(FILE_BYTES));
  endfunction

  always_comb
  begin
    logic [FILE_W:0] hit;
    logic [14:0] ofs;
    logic [15:0] span;
    logic [7:0] cnt;
    logic [7:0] cur;
    logic [7:0] rec;
    logic [2:0] mode;
    logic [4:0] sref;
    file_desc_t fd;
    hit = '0;
    ofs = '0;
    span = '0;
    cnt = '0;
    cur = '0;
    rec = '0;
    mode = cmd.p2[`P2_MODE_HI:0];
    sref = cmd.p2[`P2_SFI_HI:`P2_SFI_LO];
    dec_st = ST_OK;
    tgt = cur_file;
    start = '0;
    count = '0;
    go_read = 1'b0;
    go_write = 1'b0;
    ptr_wr = 1'b0;
    ptr_new = `REC_UNSET;
    sresp = SR_NONE;
    ind_init = 1'b0;
    ind_term = 1'b0;
    fd = file_desc[cur_file];
    case (cmd.kind)
      CMD_STATUS:
      begin
        // Le is not checked: absent, zero and sized forms all pass.
        if (cmd.lc_present)
          dec_st = ST_BAD_PARAM;
        case (cmd.p1)
          `STAT_P1_NONE: ;
          `STAT_P1_INIT: ind_init = 1'b1;
          `STAT_P1_TERM: ind_term = 1'b1;
          default: dec_st = ST_BAD_PARAM;
        endcase
        case (cmd.p2)
          `STAT_P2_SELECT: sresp = SR_SELECT;
          `STAT_P2_NAME: sresp = SR_NAME;
          `STAT_P2_NONE: sresp = SR_NONE;
          default: dec_st = ST_BAD_PARAM;
        endcase
      end
      CMD_READ_BIN, CMD_UPDATE_BIN:
      begin
        // Both binary commands share one P1/P2 decode.
        if (!cmd.p1[`P1_SFI_FLAG])
        begin
          ofs = {cmd.p1[`P1_OFS_HI:0], cmd.p2};
        end
        else if (cmd.p1[`P1_TAG_HI:`P1_TAG_LO] == `P1_SFI_TAG)
        begin
          hit = find_sfi(cmd.p1[`P1_SFI_HI:0], file_desc);
          tgt = hit[FILE_W-1:0];
          ofs = {7'h00, cmd.p2};
          if (!hit[FILE_W])
            dec_st = ST_NO_FILE;
        end
        else
          dec_st = ST_BAD_PARAM;
        fd = file_desc[tgt];
        if (cmd.kind == CMD_READ_BIN)
          count = le_bytes(cmd.le);
        else
          count = {1'b0, cmd.lc};
        span = 16'(ofs) + 16'(count);
        if (dec_st != ST_OK)
          ;
        else if (cmd.kind == CMD_READ_BIN && cmd.lc_present)
          dec_st = ST_BAD_PARAM;
        else if (cmd.kind == CMD_READ_BIN && !cmd.le_present)
          dec_st = ST_WRONG_LENGTH;
        else if (cmd.kind == CMD_UPDATE_BIN && cmd.le_present)
          dec_st = ST_BAD_PARAM;
        else if (fd.kind != FK_TRANSPARENT)
          dec_st = ST_WRONG_KIND;
        else if (cmd.kind == CMD_READ_BIN && !fd.read_ok)
          dec_st = ST_NO_ACCESS;
        else if (cmd.kind == CMD_UPDATE_BIN && !fd.update_ok)
          dec_st = ST_NO_ACCESS;
        else if (span > 16'(FILE_BYTES))
          dec_st = ST_OUT_OF_RANGE;
        start = base_of(tgt) + ADDR_W'(ofs);
        go_read = (dec_st == ST_OK) && (cmd.kind == CMD_READ_BIN);
        go_write = (dec_st == ST_OK) && (cmd.kind == CMD_UPDATE_BIN) && (count != '0);
      end
      CMD_READ_REC:
      begin
        // Coding faults are reported before any file lookup, so a reserved mode always wins.
        if (sref == `SFI_RESERVED || !(mode inside {`MODE_NEXT, `MODE_PREV, `MODE_ABS}))
          dec_st = ST_BAD_PARAM;
        else if (sref != `SFI_CURRENT)
        begin
          hit = find_sfi(sref, file_desc);
          tgt = hit[FILE_W-1:0];
          if (!hit[FILE_W])
            dec_st = ST_NO_FILE;
        end
        fd = file_desc[tgt];
        cnt = fd.rec_cnt;
        cur = ptr_q[tgt];
        rec = cur;
        if (dec_st != ST_OK)
          ;
        else if (cmd.lc_present || !cmd.le_present)
          dec_st = ST_BAD_PARAM;
        else if (fd.kind != FK_LINEAR && fd.kind != FK_CYCLIC)
          dec_st = ST_WRONG_KIND;
        else if (!fd.read_ok)
          dec_st = ST_NO_ACCESS;
        else if (cnt == '0 || fd.rec_len == '0)
          dec_st = ST_NO_RECORD;
        else
        begin
          // P1 is ignored in next and previous modes.
          case (mode)
            `MODE_NEXT:
            begin
              if (cur == `REC_UNSET)
                rec = `REC_FIRST;
              else if (cur < cnt)
                rec = cur + 8'h01;
              else if (fd.kind == FK_CYCLIC)
                rec = `REC_FIRST;
              else
                dec_st = ST_NO_RECORD;
              ptr_wr = 1'b1;
            end
            `MODE_PREV:
            begin
              if (cur == `REC_UNSET)
                rec = cnt;
              else if (cur > `REC_FIRST)
                rec = cur - 8'h01;
              else if (fd.kind == FK_CYCLIC)
                rec = cnt;
              else
                dec_st = ST_NO_RECORD;
              ptr_wr = 1'b1;
            end
            `MODE_ABS:
            begin
              if (cmd.p1 == `REC_CURRENT)
                rec = cur;
              else
                rec = cmd.p1;
            end
            default: dec_st = ST_BAD_PARAM;
          endcase
          if (dec_st == ST_OK && (rec == `REC_UNSET || rec > cnt))
            dec_st = ST_NO_RECORD;
          else if (dec_st == ST_OK && cmd.le != `LE_ZERO && cmd.le != fd.rec_len)
            dec_st = ST_WRONG_LENGTH;
        end
        // Only a successful next or previous read moves the pointer.
        ptr_wr = ptr_wr && (dec_st == ST_OK);
        ptr_new = rec;
        count = {1'b0, fd.rec_len};
        start = base_of(tgt) + ADDR_W'(16'(rec - 8'h01) * 16'(fd.rec_len));
        go_read = (dec_st == ST_OK);
      end
      default: dec_st = ST_BAD_PARAM;
    endcase
  end

  // Sequencing of accepted commands.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      ready_q <= 1'b1;
      addr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          if (accept && go_read)
          begin
            state_q <= S_READ;
            ready_q <= 1'b0;
          end
          else if (accept && go_write)
          begin
            state_q <= S_WRITE;
            ready_q <= 1'b0;
          end
          if (accept)
          begin
            addr_q <= start;
            cnt_q <= count;
          end
        end
        S_READ:
        begin
          addr_q <= addr_q + ADDR_W'(1);
          cnt_q <= cnt_q - 9'h001;
          if (cnt_q == 9'h001)
          begin
            state_q <= S_IDLE;
            ready_q <= 1'b1;
          end
        end
        S_WRITE:
        begin
          if (wr_valid)
          begin
            addr_q <= addr_q + ADDR_W'(1);
            cnt_q <= cnt_q - 9'h001;
            if (cnt_q == 9'h001)
            begin
              state_q <= S_IDLE;
              ready_q <= 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= S_IDLE;
          ready_q <= 1'b1;
        end
      endcase
    end
  end

  // File contents; only an update in progress writes them.
  always_ff @(posedge clk)
  begin
    if (state_q == S_WRITE && wr_valid)
      mem[addr_q] <= wr_data;
  end

  // Record pointers; a new selection unsets every pointer except one written by a command accepted in the same cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_FILES; i++)
        ptr_q[i] <= `REC_UNSET;
    end
    else
    begin
      if (select_pulse)
      begin
        for (int i = 0; i < NUM_FILES; i++)
          ptr_q[i] <= `REC_UNSET;
      end
      if (accept && ptr_wr)
        ptr_q[tgt] <= ptr_new;
    end
  end

  // Response bytes, one per cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
      rsp_q <= '0;
    else if (state_q == S_READ)
    begin
      rsp_q.valid <= 1'b1;
      rsp_q.data <= mem[addr_q];
      rsp_q.last <= (cnt_q == 9'h001);
    end
    else
      rsp_q <= '0;
  end

  // Completion result and application indications.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      res_q <= '0;
      init_q <= 1'b0;
      term_q <= 1'b0;
    end
    else
    begin
      res_q.done <= 1'b0;
      init_q <= 1'b0;
      term_q <= 1'b0;
      if (accept && !go_read && !go_write)
      begin
        res_q.done <= 1'b1;
        res_q.status <= dec_st;
        res_q.resp <= (dec_st == ST_OK) ? sresp : SR_NONE;
        init_q <= (dec_st == ST_OK) && (cmd.kind == CMD_STATUS) && ind_init;
        term_q <= (dec_st == ST_OK) && (cmd.kind == CMD_STATUS) && ind_term;
      end
      else if (cnt_q == 9'h001 && (state_q == S_READ || (state_q == S_WRITE && wr_valid)))
      begin
        res_q.done <= 1'b1;
        res_q.status <= ST_OK;
        res_q.resp <= SR_NONE;
      end
    end
  end

  assign cmd_ready = ready_q;
  assign rsp = rsp_q;
  assign result = res_q;
  assign app_init = init_q;
  assign app_term = term_q;

endmodule
`default_nettype wire

// file: core/card_file_regs.svh
// Parameter codings and field positions for the card file access commands.
`ifndef CARD_FILE_REGS_SVH
`define CARD_FILE_REGS_SVH

// Status command indications and response selectors.
`define STAT_P1_NONE 8'h00
`define STAT_P1_INIT 8'h01
`define STAT_P1_TERM 8'h02
`define STAT_P2_SELECT 8'h00
`define STAT_P2_NAME 8'h01
`define STAT_P2_NONE 8'h0C

// Binary command P1 layout.
`define P1_SFI_FLAG 7
`define P1_TAG_HI 7
`define P1_TAG_LO 5
`define P1_SFI_TAG 3'h4
`define P1_SFI_HI 4
`define P1_OFS_HI 6

// Record command P2 layout and codes.
`define P2_SFI_HI 7
`define P2_SFI_LO 3
`define P2_MODE_HI 2
`define SFI_CURRENT 5'h00
`define SFI_RESERVED 5'h1F
`define MODE_NEXT 3'h2
`define MODE_PREV 3'h3
`define MODE_ABS 3'h4
`define REC_CURRENT 8'h00
`define REC_UNSET 8'h00
`define REC_FIRST 8'h01
`define LE_ZERO 8'h00
`define LE_FULL 9'h100

`endif

// file: core/card_file_pkg.sv
// Types shared by the card file access command block.
package card_file_pkg;

  typedef enum logic [1:0] {
    CMD_STATUS,
    CMD_READ_BIN,
    CMD_UPDATE_BIN,
    CMD_READ_REC
  } cmd_kind_t;

  typedef enum logic [2:0] {
    ST_OK,
    ST_BAD_PARAM,
    ST_NO_ACCESS,
    ST_NO_FILE,
    ST_OUT_OF_RANGE,
    ST_NO_RECORD,
    ST_WRONG_KIND,
    ST_WRONG_LENGTH
  } status_t;

  typedef enum logic [1:0] {
    SR_NONE,
    SR_SELECT,
    SR_NAME
  } stat_resp_t;

  typedef enum logic [1:0] {
    FK_TRANSPARENT,
    FK_LINEAR,
    FK_CYCLIC,
    FK_OTHER
  } file_kind_t;

  typedef struct packed {
    cmd_kind_t kind;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
    logic lc_present;
    logic [7:0] le;
    logic le_present;
  } cmd_t;

  typedef struct packed {
    file_kind_t kind;
    logic [4:0] short_file_ref;
    logic read_ok;
    logic update_ok;
    logic [7:0] rec_len;
    logic [7:0] rec_cnt;
  } file_desc_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } rsp_byte_t;

  typedef struct packed {
    logic done;
    status_t status;
    stat_resp_t resp;
  } result_t;

endpackage

// file: dv/card_file_access_asserts.sv
// Concurrent checks on the ports of the card file access block.
`timescale 1ns/1ps
`default_nettype none
module card_file_access_asserts
  import card_file_pkg::*;
#(
  parameter int NUM_FILES = 4,
  parameter int FILE_W = 2
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command side
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  // File system view
  input wire file_desc_t [NUM_FILES-1:0] file_desc,
  input wire logic [FILE_W-1:0] cur_file,
  input wire logic select_pulse,
  // Results
  input wire rsp_byte_t rsp,
  input wire result_t result,
  input wire logic app_init,
  input wire logic app_term
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire take = cmd_valid && cmd_ready;
  wire stat = take && cmd.kind == CMD_STATUS && !cmd.lc_present;

  property p_init;
    app_init |-> result.done && $past(stat && cmd.p1 == 8'h01);
  endproperty
  a_init: assert property (p_init) else $error("init pulse without its command");
  property p_term;
    app_term |-> result.done && $past(stat && cmd.p1 == 8'h02);
  endproperty
  a_term: assert property (p_term) else $error("term pulse without its command");
  property p_sel;
    stat && cmd.p1 == 8'h00 && cmd.p2 == 8'h00
      |=> result.done && result.status == ST_OK && result.resp == SR_SELECT && !app_init;
  endproperty
  a_sel: assert property (p_sel) else $error("status select response wrong");
  property p_none;
    stat && cmd.p1 == 8'h02 && cmd.p2 == 8'h0C
      |=> result.done && result.status == ST_OK && result.resp == SR_NONE && app_term;
  endproperty
  a_none: assert property (p_none) else $error("status no-data response wrong");
  property p_stat_bad;
    take && cmd.kind == CMD_STATUS && !(cmd.p2 inside {8'h00, 8'h01, 8'h0C})
      |=> result.done && result.status == ST_BAD_PARAM && !app_init && !app_term;
  endproperty
  a_stat_bad: assert property (p_stat_bad) else $error("reserved status P2 accepted");
  property p_mode_bad;
    take && cmd.kind == CMD_READ_REC && !(cmd.p2[2:0] inside {3'h2, 3'h3, 3'h4})
      |=> result.done && result.status == ST_BAD_PARAM && !rsp.valid;
  endproperty
  a_mode_bad: assert property (p_mode_bad) else $error("reserved record mode accepted");
  property p_rd_lc;
    take && cmd.kind == CMD_READ_BIN && !cmd.p1[7] && cmd.lc_present
      |=> result.done && result.status == ST_BAD_PARAM;
  endproperty
  a_rd_lc: assert property (p_rd_lc) else $error("binary read with data length accepted");
  property p_upd_le;
    take && cmd.kind == CMD_UPDATE_BIN && !cmd.p1[7] && cmd.le_present
      |=> result.done && result.status == ST_BAD_PARAM;
  endproperty
  a_upd_le: assert property (p_upd_le) else $error("update with response length accepted");
  property p_err_quiet;
    result.done && result.status != ST_OK |-> !rsp.valid;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("bytes sent with an error");
  property p_last;
    rsp.valid && rsp.last |-> result.done && result.status == ST_OK;
  endproperty
  a_last: assert property (p_last) else $error("last byte without done");
  property p_stream;
    rsp.valid && !rsp.last |=> rsp.valid;
  endproperty
  a_stream: assert property (p_stream) else $error("response stream broken");
  c_init: cover property (app_init);
  c_last: cover property (rsp.valid && rsp.last);
  c_norec: cover property (result.done && result.status == ST_NO_RECORD);
endmodule
bind card_file_access card_file_access_asserts #(.NUM_FILES(NUM_FILES), .FILE_W(FILE_W)) chk_u (
  .clk, .reset, .cmd_valid, .cmd, .cmd_ready, .wr_valid, .wr_data, .file_desc,
  .cur_file, .select_pulse, .rsp, .result, .app_init, .app_term);
`default_nettype wire

// file: dv/terminal_model.sv
// Terminal model that streams update data once an update command is taken.
`timescale 1ns/1ps
`default_nettype none
module terminal_model
  import card_file_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command snoop
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic slow,
  // Update data
  output logic wr_valid,
  output logic [7:0] wr_data
);
  logic [8:0] left_q;
  logic [7:0] ofs_q;

  // Byte value is the low offset scrambled, so the reader can predict it.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      left_q <= 9'h000;
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
    end
    else if (cmd_valid && cmd_ready && cmd.kind == CMD_UPDATE_BIN)
    begin
      left_q <= {1'b0, cmd.lc};
      ofs_q <= cmd.p2;
      wr_valid <= 1'b0;
      wr_data <= ~wr_data;
    end
    else if (left_q != 9'h000 && !(slow && wr_valid))
    begin
      left_q <= left_q - 9'h001;
      ofs_q <= ofs_q + 8'h01;
      wr_valid <= 1'b1;
      wr_data <= ofs_q ^ 8'h5A;
    end
    else
    begin
      wr_valid <= 1'b0;
      wr_data <= ~wr_data;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the card file access command block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import card_file_pkg::*;
  logic clk;
  logic reset;
  logic cmd_valid;
  cmd_t cmd;
  logic cmd_ready;
  logic wr_valid;
  logic [7:0] wr_data;
  file_desc_t [3:0] file_desc;
  logic [1:0] cur_file;
  logic select_pulse;
  logic slow;
  rsp_byte_t rsp;
  result_t result;
  logic app_init;
  logic app_term;
  int miscompares;
  int num_checks;
  int cycles;
  int i;
  logic [7:0] got[$];
  status_t st;
  stat_resp_t sr;
  logic [7:0] p2tab[3] = '{8'h00, 8'h01, 8'h0C};
  stat_resp_t srtab[3] = '{SR_SELECT, SR_NAME, SR_NONE};

  card_file_access dut_u (.clk, .reset, .cmd_valid, .cmd, .cmd_ready, .wr_valid, .wr_data,
    .file_desc, .cur_file, .select_pulse, .rsp, .result, .app_init, .app_term);
  terminal_model term_u (.clk, .reset, .cmd_valid, .cmd, .cmd_ready, .slow, .wr_valid, .wr_data);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      miscompares++;
    end
  endtask

  task automatic run(cmd_kind_t k, logic [7:0] p1, p2, lc, le, logic lcp, lep);
    int n;
    got = {};
    while (cmd_ready !== 1'b1)
      step();
    cmd_valid = 1'b1;
    cmd = '{k, p1, p2, lc, lcp, le, lep};
    step();
    cmd_valid = 1'b0;
    for (n = 0; n < 400 && result.done !== 1'b1; n++)
    begin
      if (rsp.valid === 1'b1)
        got.push_back(rsp.data);
      step();
    end
    if (rsp.valid === 1'b1)
      got.push_back(rsp.data);
    st = result.status;
    sr = result.resp;
    step();
  endtask

  task automatic rd(logic [7:0] p1, p2, le, status_t exp, int n);
    run(CMD_READ_BIN, p1, p2, 8'h00, le, 1'b0, 1'b1);
    chk("read status", exp, st);
    chk("read count", n, got.size());
  endtask

  task automatic wr(logic [7:0] p1, p2, lc, status_t exp);
    run(CMD_UPDATE_BIN, p1, p2, lc, 8'h00, 1'b1, 1'b0);
    chk("update status", exp, st);
  endtask

  task automatic data_is(logic [7:0] base);
    foreach (got[j])
      chk("read data", (base + j[7:0]) ^ 8'h5A, got[j]);
  endtask

  task automatic rec(logic [7:0] p1, p2, status_t exp);
    run(CMD_READ_REC, p1, p2, 8'h00, 8'h02, 1'b0, 1'b1);
    chk("record status", exp, st);
    chk("record count", exp == ST_OK ? 2 : 0, got.size());
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    cur_file = 2'h0;
    select_pulse = 1'b0;
    slow = 1'b0;
    file_desc[0] = '{FK_TRANSPARENT, 5'h01, 1'b1, 1'b1, 8'h00, 8'h00};
    file_desc[1] = '{FK_LINEAR, 5'h02, 1'b1, 1'b1, 8'h02, 8'h03};
    file_desc[2] = '{FK_CYCLIC, 5'h03, 1'b1, 1'b1, 8'h02, 8'h03};
    file_desc[3] = '{FK_TRANSPARENT, 5'h04, 1'b0, 1'b0, 8'h00, 8'h00};
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    for (i = 0; i < 9; i++)
    begin
      run(CMD_STATUS, i % 3, p2tab[i / 3], 8'h00, (i % 3 == 2) ? 8'h20 : 8'h00, 1'b0, i % 3 != 0);
      chk("status ok", ST_OK, st);
      chk("status resp", srtab[i / 3], sr);
    end
    run(CMD_STATUS, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("status p2", ST_BAD_PARAM, st);
    run(CMD_STATUS, 8'h03, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("status p1", ST_BAD_PARAM, st);
    slow = 1'b1;
    wr(8'h00, 8'hF0, 8'h10, ST_OK);
    slow = 1'b0;
    rd(8'h00, 8'hF0, 8'h10, ST_OK, 16);
    data_is(8'hF0);
    wr(8'h81, 8'h20, 8'h04, ST_OK);
    rd(8'h00, 8'h20, 8'h04, ST_OK, 4);
    data_is(8'h20);
    rd(8'h81, 8'hF0, 8'h10, ST_OK, 16);
    data_is(8'hF0);
    rd(8'h01, 8'h00, 8'h01, ST_OUT_OF_RANGE, 0);
    rd(8'h00, 8'h00, 8'h00, ST_OK, 256);
    rd(8'h84, 8'h00, 8'h01, ST_NO_ACCESS, 0);
    rd(8'h85, 8'h00, 8'h01, ST_NO_FILE, 0);
    rd(8'hA1, 8'h00, 8'h01, ST_BAD_PARAM, 0);
    run(CMD_READ_BIN, 8'h00, 8'h00, 8'h01, 8'h01, 1'b1, 1'b1);
    chk("read with lc", ST_BAD_PARAM, st);
    run(CMD_UPDATE_BIN, 8'h00, 8'h00, 8'h00, 8'h01, 1'b1, 1'b1);
    chk("update with le", ST_BAD_PARAM, st);
    cur_file = 2'h3;
    wr(8'h00, 8'h00, 8'h00, ST_NO_ACCESS);
    rd(8'h00, 8'h00, 8'h01, ST_NO_ACCESS, 0);
    cur_file = 2'h1;
    // P1 stays zero for next and previous modes.
    rec(8'h00, 8'h04, ST_NO_RECORD);
    rec(8'h00, 8'h02, ST_OK);
    rec(8'h00, 8'h02, ST_OK);
    rec(8'h00, 8'h02, ST_OK);
    rec(8'h00, 8'h02, ST_NO_RECORD);
    rec(8'h00, 8'h04, ST_OK);
    rec(8'h02, 8'h04, ST_OK);
    rec(8'h04, 8'h04, ST_NO_RECORD);
    rec(8'h00, 8'h02, ST_NO_RECORD);
    rec(8'h00, 8'h03, ST_OK);
    rec(8'h00, 8'h03, ST_OK);
    rec(8'h00, 8'h03, ST_NO_RECORD);
    rec(8'h00, 8'h02, ST_OK);
    select_pulse = 1'b1;
    step();
    select_pulse = 1'b0;
    rec(8'h00, 8'h03, ST_OK);
    rec(8'h00, 8'h02, ST_NO_RECORD);
    rec(8'h00, 8'h1B, ST_OK);
    rec(8'h00, 8'h1A, ST_OK);
    rec(8'h00, 8'h1B, ST_OK);
    rec(8'h00, 8'h4A, ST_NO_FILE);
    rec(8'h00, 8'hFA, ST_BAD_PARAM);
    rec(8'h00, 8'h05, ST_BAD_PARAM);
    run(CMD_READ_REC, 8'h01, 8'h04, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("record le zero", 2, got.size());
    run(CMD_READ_REC, 8'h01, 8'h04, 8'h00, 8'h03, 1'b0, 1'b1);
    chk("record le", ST_WRONG_LENGTH, st);
    cur_file = 2'h0;
    rec(8'h00, 8'h02, ST_WRONG_KIND);
    report_and_stop();
  end
endmodule
`default_nettype wire
